// ### src/mbar_pkg.sv
package mbar_pkg;

	// ----------------------------------------
	// Function codes, exceptions and TCP port
	// ----------------------------------------
	localparam logic [7:0]  FC_READ_HOLD     = 8'h03;
	localparam logic [7:0]  FC_READ_INPUT    = 8'h04;
	localparam logic [7:0]  FC_EXC_FLAG      = 8'h80;
	localparam logic [7:0]  EXC_BAD_FUNC     = 8'h01;
	localparam logic [7:0]  EXC_BAD_ADDR     = 8'h02;
	localparam logic [15:0] MODBUS_TCP_PORT  = 16'h01f6;

	// ----------------------------------------
	// Accepted ranges per value format
	// ----------------------------------------
	localparam logic [15:0] ADDR_MAX_FLOAT   = 16'h000e;
	localparam logic [15:0] ADDR_MAX_COUNT   = 16'h000e;
	localparam logic [15:0] QTY_MIN          = 16'h0001;
	localparam logic [15:0] QTY_MAX_FLOAT    = 16'h0008;
	localparam logic [15:0] QTY_MAX_COUNT    = 16'h0010;

	// ----------------------------------------
	// Frame layout and size defaults
	// ----------------------------------------
	localparam logic [2:0]  REQ_POS_FC       = 3'h0;
	localparam logic [2:0]  REQ_POS_ADDR_HI  = 3'h1;
	localparam logic [2:0]  REQ_POS_ADDR_LO  = 3'h2;
	localparam logic [2:0]  REQ_POS_QTY_HI   = 3'h3;
	localparam logic [2:0]  REQ_POS_QTY_LO   = 3'h4;
	localparam int          DEF_NUM_CH       = 8;
	localparam int          DEF_ARR_DEPTH    = 16;

	// ----------------------------------------
	// State machines
	// ----------------------------------------
	typedef enum logic [4:0] {
		SLV_IDLE = 5'h01,
		SLV_FC   = 5'h02,
		SLV_BC   = 5'h04,
		SLV_DATA = 5'h08,
		SLV_EXC  = 5'h10
	} mbar_slv_e;

	typedef enum logic [5:0] {
		MST_IDLE = 6'h01,
		MST_SEND = 6'h02,
		MST_FC   = 6'h04,
		MST_BC   = 6'h08,
		MST_DATA = 6'h10,
		MST_EXC  = 6'h20
	} mbar_mst_e;

endpackage

// ### src/mbar_mem_if.sv
`timescale 1ns/100ps
interface mbar_mem_if #(
	parameter int AW = 4,
	parameter int DW = 16
);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ### src/mbar_regmem.sv
`timescale 1ns/100ps
module mbar_regmem #(
	parameter int DEPTH = 16,
	parameter int AW    = 4,
	parameter int DW    = 16
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	mbar_mem_if.mem  port
);
	// Index must reach every stored word
	if ((1 << AW) < DEPTH || DW < 1) begin : g_chk
		$error("mbar_regmem: AW too narrow for DEPTH or DW zero");
	end
	// ----------------------------------------
	// Storage, registered read
	// ----------------------------------------
	logic [DW-1:0] mem_q [DEPTH];

	always_ff @(posedge ref_clk_i) begin
		if (port.wr_en) begin
			mem_q[port.wr_addr] <= port.wr_data;
		end
		if (sys_rst_i) begin
			port.rd_data <= '0;
		end else begin
			port.rd_data <= mem_q[port.rd_addr];
		end
	end
endmodule

// ### src/mbar_top.sv
`timescale 1ns/100ps
module mbar_top #(
	parameter int NUM_CH    = mbar_pkg::DEF_NUM_CH,
	parameter int ARR_DEPTH = mbar_pkg::DEF_ARR_DEPTH,
	parameter int AW        = $clog2(mbar_pkg::DEF_ARR_DEPTH)
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  value_format_select_i,
	input  wire logic                  function_swap_select_i,
	input  wire logic [NUM_CH*32-1:0]  an_float_i,
	input  wire logic [NUM_CH*16-1:0]  an_count_i,
	input  wire logic [NUM_CH*32-1:0]  ao_float_i,
	input  wire logic [NUM_CH*16-1:0]  ao_count_i,
	input  wire logic                  rx_valid_i,
	input  wire logic [7:0]            rx_data_i,
	input  wire logic [15:0]           rx_port_i,
	output logic                       rx_ready_o,
	output logic                       tx_valid_o,
	output logic [7:0]                 tx_data_o,
	output logic                       tx_last_o,
	output logic [15:0]                tx_port_o,
	input  wire logic                  tx_ready_i,
	input  wire logic                  modbus_send_command_i,
	input  wire logic [7:0]            mst_fc_i,
	input  wire logic [15:0]           mst_addr_i,
	input  wire logic [15:0]           mst_qty_i,
	output logic                       mst_tx_valid_o,
	output logic [7:0]                 mst_tx_data_o,
	output logic                       mst_tx_last_o,
	input  wire logic                  mst_tx_ready_i,
	input  wire logic                  mst_rx_valid_i,
	input  wire logic [7:0]            mst_rx_data_i,
	input  wire logic [15:0]           mst_rx_port_i,
	output logic                       mst_busy_o,
	output logic                       mst_done_o,
	output logic [7:0]                 response_function_query_o,
	output logic [7:0]                 exception_code_query_o,
	input  wire logic [AW-1:0]         analog_array_addr_i,
	output logic [15:0]                analog_array_data_o
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Register map only spans eight channels; array must hold a full reply
	if (NUM_CH < 1 || NUM_CH > 8 || ARR_DEPTH < 16 || (1 << AW) < ARR_DEPTH) begin : g_chk
		$error("mbar_top: unsupported NUM_CH, ARR_DEPTH or AW");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		mbar_pkg::mbar_slv_e sst;
		logic [2:0]          rcnt;
		logic [7:0]          fc;
		logic [15:0]         addr;
		logic [15:0]         qty;
		logic [7:0]          exc;
		logic [5:0]          idx;
		logic [7:0]          tx_data;
		mbar_pkg::mbar_mst_e mst;
		logic [2:0]          mcnt;
		logic [7:0]          mfc;
		logic [15:0]         maddr;
		logic [15:0]         mqty;
		logic [7:0]          mtx_data;
		logic [7:0]          bc;
		logic [7:0]          mbytes;
		logic [7:0]          hi;
		logic [7:0]          resp_fc;
		logic [7:0]          resp_exc;
		logic                done;
	} mbar_state_s;
	mbar_state_s r_reg;
	mbar_state_s r_next;
	mbar_mem_if #(.AW(AW), .DW(16)) mem_bus ();
	// Register word at a map address; unused channels read zero
	function automatic logic [15:0] mbar_fetch(
		input logic                 counts,
		input logic [15:0]          regno,
		input logic [NUM_CH*32-1:0] flt,
		input logic [NUM_CH*16-1:0] cnt
	);
		logic [15:0] ch, w;
		ch = counts ? regno : (regno >> 1);
		w  = 16'h0000;
		for (int i = 0; i < NUM_CH; i++) begin
			if (ch == 16'(i)) begin
				// Counts one word per channel, float high word at even address
				w = counts ? cnt[i*16 +: 16] :
					(regno[0] ? flt[i*32 +: 16] : flt[i*32+16 +: 16]);
			end
		end
		return w;
	endfunction
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic        use_an, counts;
	logic [15:0] qty_in, regno, word;
	logic [5:0]  nidx, last_idx;
	always_comb begin
		r_next          = r_reg;
		r_next.done     = 1'b0;
		counts          = value_format_select_i;
		use_an          = (r_reg.fc == mbar_pkg::FC_READ_HOLD) ^ function_swap_select_i;
		qty_in          = {r_reg.qty[15:8], rx_data_i};
		last_idx        = 6'(({r_reg.qty[4:0], 1'b0}) - 6'h01);
		nidx            = (r_reg.sst == mbar_pkg::SLV_DATA) ? 6'(r_reg.idx + 6'h01) : 6'h00;
		regno           = 16'(r_reg.addr + 16'(nidx[5:1]));
		word            = use_an ? mbar_fetch(counts, regno, an_float_i, an_count_i)
		                         : mbar_fetch(counts, regno, ao_float_i, ao_count_i);
		mem_bus.wr_en   = 1'b0;
		mem_bus.wr_addr = AW'(r_reg.mbytes >> 1);
		mem_bus.wr_data = {r_reg.hi, mst_rx_data_i};
		mem_bus.rd_addr = analog_array_addr_i;
		case (r_reg.sst)
		mbar_pkg::SLV_IDLE: begin
			if (rx_valid_i && rx_port_i == mbar_pkg::MODBUS_TCP_PORT) begin
				r_next.rcnt = 3'(r_reg.rcnt + 3'h1);
				case (r_reg.rcnt)
				mbar_pkg::REQ_POS_FC:      r_next.fc = rx_data_i;
				mbar_pkg::REQ_POS_ADDR_HI: r_next.addr[15:8] = rx_data_i;
				mbar_pkg::REQ_POS_ADDR_LO: r_next.addr[7:0] = rx_data_i;
				mbar_pkg::REQ_POS_QTY_HI:  r_next.qty[15:8] = rx_data_i;
				default: begin
					r_next.qty  = qty_in;
					r_next.rcnt = 3'h0;
					r_next.sst  = mbar_pkg::SLV_FC;
					r_next.exc  = 8'h00;
					if (r_reg.fc != mbar_pkg::FC_READ_HOLD && r_reg.fc != mbar_pkg::FC_READ_INPUT) begin
						r_next.exc = mbar_pkg::EXC_BAD_FUNC;
					end else if (counts ?
						(r_reg.addr > mbar_pkg::ADDR_MAX_COUNT || qty_in < mbar_pkg::QTY_MIN ||
						 qty_in > mbar_pkg::QTY_MAX_COUNT) :
						(r_reg.addr > mbar_pkg::ADDR_MAX_FLOAT || qty_in < mbar_pkg::QTY_MIN ||
						 qty_in > mbar_pkg::QTY_MAX_FLOAT)) begin
						r_next.exc = mbar_pkg::EXC_BAD_ADDR;
					end
					r_next.tx_data = (r_next.exc != 8'h00) ? (r_reg.fc | mbar_pkg::FC_EXC_FLAG)
					                                       : r_reg.fc;
				end
				endcase
			end
		end
		mbar_pkg::SLV_FC: begin
			if (tx_ready_i) begin
				if (r_reg.exc != 8'h00) begin
					r_next.sst     = mbar_pkg::SLV_EXC;
					r_next.tx_data = r_reg.exc;
				end else begin
					r_next.sst     = mbar_pkg::SLV_BC;
					r_next.tx_data = {r_reg.qty[6:0], 1'b0};
				end
			end
		end
		mbar_pkg::SLV_BC: begin
			if (tx_ready_i) begin
				r_next.sst     = mbar_pkg::SLV_DATA;
				r_next.idx     = 6'h00;
				r_next.tx_data = word[15:8];
			end
		end
		mbar_pkg::SLV_DATA: begin
			if (tx_ready_i) begin
				if (r_reg.idx == last_idx) begin
					r_next.sst = mbar_pkg::SLV_IDLE;
				end else begin
					r_next.idx     = nidx;
					r_next.tx_data = nidx[0] ? word[7:0] : word[15:8];
				end
			end
		end
		mbar_pkg::SLV_EXC: begin
			if (tx_ready_i) begin
				r_next.sst = mbar_pkg::SLV_IDLE;
			end
		end
		default: r_next.sst = mbar_pkg::SLV_IDLE;
		endcase
		case (r_reg.mst)
		mbar_pkg::MST_IDLE: begin
			if (modbus_send_command_i) begin
				r_next.mst      = mbar_pkg::MST_SEND;
				r_next.mfc      = mst_fc_i;
				r_next.maddr    = mst_addr_i;
				r_next.mqty     = mst_qty_i;
				r_next.mcnt     = 3'h0;
				r_next.mtx_data = mst_fc_i;
			end
		end
		mbar_pkg::MST_SEND: begin
			if (mst_tx_ready_i) begin
				r_next.mcnt = 3'(r_reg.mcnt + 3'h1);
				case (r_reg.mcnt)
				mbar_pkg::REQ_POS_FC:      r_next.mtx_data = r_reg.maddr[15:8];
				mbar_pkg::REQ_POS_ADDR_HI: r_next.mtx_data = r_reg.maddr[7:0];
				mbar_pkg::REQ_POS_ADDR_LO: r_next.mtx_data = r_reg.mqty[15:8];
				mbar_pkg::REQ_POS_QTY_HI:  r_next.mtx_data = r_reg.mqty[7:0];
				default:                   r_next.mst = mbar_pkg::MST_FC;
				endcase
			end
		end
		mbar_pkg::MST_FC: begin
			if (mst_rx_valid_i && mst_rx_port_i == mbar_pkg::MODBUS_TCP_PORT) begin
				r_next.resp_fc  = mst_rx_data_i;
				r_next.resp_exc = 8'h00;
				r_next.mst      = mst_rx_data_i[7] ? mbar_pkg::MST_EXC : mbar_pkg::MST_BC;
			end
		end
		mbar_pkg::MST_BC: begin
			if (mst_rx_valid_i && mst_rx_port_i == mbar_pkg::MODBUS_TCP_PORT) begin
				r_next.bc     = mst_rx_data_i;
				r_next.mbytes = 8'h00;
				if (mst_rx_data_i == 8'h00) begin
					r_next.mst  = mbar_pkg::MST_IDLE;
					r_next.done = 1'b1;
				end else begin
					r_next.mst = mbar_pkg::MST_DATA;
				end
			end
		end
		mbar_pkg::MST_DATA: begin
			if (mst_rx_valid_i && mst_rx_port_i == mbar_pkg::MODBUS_TCP_PORT) begin
				r_next.mbytes = 8'(r_reg.mbytes + 8'h01);
				if (!r_reg.mbytes[0]) begin
					r_next.hi = mst_rx_data_i;
				end else begin
					// Overflow past the array is dropped rather than wrapped
					mem_bus.wr_en = ((r_reg.mbytes >> 1) < 8'(ARR_DEPTH));
				end
				if (8'(r_reg.mbytes + 8'h01) == r_reg.bc) begin
					r_next.mst  = mbar_pkg::MST_IDLE;
					r_next.done = 1'b1;
				end
			end
		end
		mbar_pkg::MST_EXC: begin
			if (mst_rx_valid_i && mst_rx_port_i == mbar_pkg::MODBUS_TCP_PORT) begin
				r_next.resp_exc = mst_rx_data_i;
				r_next.mst      = mbar_pkg::MST_IDLE;
				r_next.done     = 1'b1;
			end
		end
		default: r_next.mst = mbar_pkg::MST_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			r_reg     <= '0;
			r_reg.sst <= mbar_pkg::SLV_IDLE;
			r_reg.mst <= mbar_pkg::MST_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end
	// ----------------------------------------
	// Array and outputs
	// ----------------------------------------
	mbar_regmem #(.DEPTH(ARR_DEPTH), .AW(AW), .DW(16)) u_mem (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.port      (mem_bus.mem)
	);

	assign analog_array_data_o       = mem_bus.rd_data;
	assign rx_ready_o                = (r_reg.sst == mbar_pkg::SLV_IDLE);
	assign tx_valid_o                = (r_reg.sst != mbar_pkg::SLV_IDLE);
	assign tx_data_o                 = r_reg.tx_data;
	assign tx_last_o                 = (r_reg.sst == mbar_pkg::SLV_EXC) ||
	                                   (r_reg.sst == mbar_pkg::SLV_DATA && r_reg.idx == last_idx);
	assign tx_port_o                 = mbar_pkg::MODBUS_TCP_PORT;
	assign mst_tx_valid_o            = (r_reg.mst == mbar_pkg::MST_SEND);
	assign mst_tx_data_o             = r_reg.mtx_data;
	assign mst_tx_last_o             = (r_reg.mst == mbar_pkg::MST_SEND) &&
	                                   (r_reg.mcnt == mbar_pkg::REQ_POS_QTY_LO);
	assign mst_busy_o                = (r_reg.mst != mbar_pkg::MST_IDLE);
	assign mst_done_o                = r_reg.done;
	assign response_function_query_o = r_reg.resp_fc;
	assign exception_code_query_o    = r_reg.resp_exc;
endmodule

// ### dv/mbar_top_props.sv
`timescale 1ns/100ps
module mbar_top_props (
	input wire logic        ref_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        rx_valid_i,
	input wire logic [15:0] rx_port_i,
	input wire logic        rx_ready_o,
	input wire logic        tx_valid_o,
	input wire logic [7:0]  tx_data_o,
	input wire logic        tx_last_o,
	input wire logic [15:0] tx_port_o,
	input wire logic        tx_ready_i,
	input wire logic        modbus_send_command_i,
	input wire logic        mst_tx_valid_o,
	input wire logic        mst_busy_o,
	input wire logic        mst_done_o,
	input wire logic [7:0]  response_function_query_o,
	input wire logic [7:0]  exception_code_query_o
);
	// ----
	// Port relations
	// ----
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_port_fixed: assert property (
		tx_port_o == 16'h01f6) else $error("reply port wrong");
	a_foreign_ignored: assert property (
		rx_valid_i && rx_ready_o && rx_port_i != 16'h01f6 |=> rx_ready_o) else $error("foreign byte");
	a_reply_start: assert property (
		$rose(tx_valid_o) |-> $past(rx_valid_i && rx_ready_o)) else $error("reply without request");
	a_byte_holds: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("byte dropped");
	a_last_ends: assert property (
		tx_valid_o && tx_last_o && tx_ready_i |=> !tx_valid_o && rx_ready_o) else $error("no idle");
	a_cmd_starts: assert property (
		modbus_send_command_i && !mst_busy_o |=> mst_busy_o && mst_tx_valid_o) else $error("no start");
	a_done_pulse: assert property (
		mst_done_o |=> !mst_done_o) else $error("done too long");
	a_exc_cleared: assert property (
		mst_done_o && !response_function_query_o[7] |-> exception_code_query_o == 8'h00)
		else $error("stale exception code");
	a_exc_kept: assert property (
		mst_done_o && response_function_query_o[7] |-> exception_code_query_o inside {8'h01, 8'h02})
		else $error("bad exception code");
	c_exc: cover property (mst_done_o && response_function_query_o[7]);
	c_last: cover property (tx_valid_o && tx_last_o && tx_ready_i);
	c_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule
bind mbar_top mbar_top_props u_props (.ref_clk_i, .sys_rst_i, .rx_valid_i, .rx_port_i, .rx_ready_o,
	.tx_valid_o, .tx_data_o, .tx_last_o, .tx_port_o, .tx_ready_i, .modbus_send_command_i,
	.mst_tx_valid_o, .mst_busy_o, .mst_done_o, .response_function_query_o,
	.exception_code_query_o);

// ### dv/mbar_far_slave.sv
`timescale 1ns/100ps
module mbar_far_slave (
	input  wire logic        clk_i,
	input  wire logic        exc_i,
	input  wire logic        slow_i,
	input  wire logic        mst_tx_valid_i,
	input  wire logic [7:0]  mst_tx_data_i,
	input  wire logic        mst_tx_last_i,
	output logic             mst_tx_ready_o,
	output logic             rx_valid_o,
	output logic [7:0]       rx_data_o,
	output logic [15:0]      rx_port_o
);
	logic [7:0] req [5];
	int         n;
	// ----
	// Remote responder
	// ----
	task automatic put(input logic [7:0] b);
		rx_valid_o = 1'b1;
		rx_data_o = b;
		@(negedge clk_i);
	endtask
	initial begin
		n = 0;
		mst_tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_data_o = 8'h5a;
		rx_port_o = 16'h01f6;
		forever begin
			@(negedge clk_i);
			// Ready is set first: it and the byte now shown meet at the coming edge
			mst_tx_ready_o = slow_i ? !mst_tx_ready_o : 1'b1;
			if (mst_tx_valid_i && mst_tx_ready_o) begin
				req[n] = mst_tx_data_i;
				n = (n + 1) % 5;
				if (mst_tx_last_i) begin
					@(negedge clk_i);
					mst_tx_ready_o = 1'b0;
					if (exc_i) begin
						put(req[0] | 8'h80);
						put(8'h02);
					end else begin
						put(req[0]);
						put({req[4][6:0], 1'b0});
						for (int k = 0; k < 2 * req[4]; k++) put(8'h30 + k[7:0]);
					end
					// Released line shows the inverse, not a stale byte
					rx_valid_o = 1'b0;
					rx_data_o = ~rx_data_o;
				end
			end
		end
	end
endmodule

// ### dv/mbar_top_tb_top.sv
`timescale 1ns/100ps
module mbar_top_tb_top;
	logic         ref_clk_i = 1'b0, sys_rst_i = 1'b1, value_format_select_i = 1'b0;
	logic         function_swap_select_i = 1'b0, rx_valid_i = 1'b0, tx_ready_i = 1'b0;
	logic         modbus_send_command_i = 1'b0, exc = 1'b0, slow = 1'b0;
	logic [255:0] an_float_i, ao_float_i;
	logic [127:0] an_count_i, ao_count_i;
	logic [7:0]   rx_data_i = 8'h00, mst_fc_i = 8'h00, tx_data_o, mst_tx_data_o, mst_rx_data_i;
	logic [7:0]   response_function_query_o, exception_code_query_o;
	logic [15:0]  rx_port_i = 16'h01f6, mst_addr_i = 16'h0000, mst_qty_i = 16'h0000;
	logic [15:0]  tx_port_o, mst_rx_port_i, analog_array_data_o;
	logic [3:0]   analog_array_addr_i = 4'h0;
	logic         rx_ready_o, tx_valid_o, tx_last_o, mst_tx_valid_o, mst_tx_last_o;
	logic         mst_tx_ready_i, mst_rx_valid_i, mst_busy_o, mst_done_o;
	int           num_errors = 0, cmp_count = 0, cycles = 0;
	mbar_top u_dut (.ref_clk_i, .sys_rst_i, .value_format_select_i, .function_swap_select_i,
		.an_float_i, .an_count_i, .ao_float_i, .ao_count_i, .rx_valid_i, .rx_data_i, .rx_port_i,
		.rx_ready_o, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_port_o, .tx_ready_i,
		.modbus_send_command_i, .mst_fc_i, .mst_addr_i, .mst_qty_i, .mst_tx_valid_o,
		.mst_tx_data_o, .mst_tx_last_o, .mst_tx_ready_i, .mst_rx_valid_i, .mst_rx_data_i,
		.mst_rx_port_i, .mst_busy_o, .mst_done_o, .response_function_query_o,
		.exception_code_query_o, .analog_array_addr_i, .analog_array_data_o);
	mbar_far_slave u_far (.clk_i(ref_clk_i), .exc_i(exc), .slow_i(slow),
		.mst_tx_valid_i(mst_tx_valid_o), .mst_tx_data_i(mst_tx_data_o),
		.mst_tx_last_i(mst_tx_last_o), .mst_tx_ready_o(mst_tx_ready_i),
		.rx_valid_o(mst_rx_valid_i), .rx_data_o(mst_rx_data_i), .rx_port_o(mst_rx_port_i));
	// ----
	// Checking helpers
	// ----
	task automatic miss(input string m);
		num_errors++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	function automatic logic [15:0] reg_val(input logic [7:0] fc, input int r);
		logic        ain;
		logic [31:0] f;
		int          c;
		ain = (fc == 8'h03) ^ function_swap_select_i;
		c = value_format_select_i ? r : r / 2;
		if (c > 7) return 16'h0000;
		if (value_format_select_i) return ain ? 16'h2500 + c[15:0] : 16'h6600 + c[15:0];
		f = ain ? 32'h3f00a000 + c : 32'h4100b000 + c;
		return (r % 2) ? f[15:0] : f[31:16];
	endfunction
	// Sends one request, drains the reply with a stalling sink, compares bytes
	task automatic slv(input logic [7:0] fc, input logic [15:0] a, q, port);
		logic [7:0]  got [$];
		logic [7:0]  exp [$];
		logic [7:0]  b [5];
		logic [15:0] v;
		bit          fin;
		b = '{fc, a[15:8], a[7:0], q[15:8], q[7:0]};
		fin = 1'b0;
		rx_port_i = port;
		foreach (b[i]) begin
			rx_valid_i = 1'b1;
			rx_data_i = b[i];
			while (rx_ready_o !== 1'b1) @(negedge ref_clk_i);
			@(negedge ref_clk_i);
		end
		rx_valid_i = 1'b0;
		rx_data_i = ~rx_data_i;
		rx_port_i = 16'h01f6;
		if (fc != 8'h03 && fc != 8'h04) exp = '{fc | 8'h80, 8'h01};
		else if (a > 16'h000e || q == 0 || q > (value_format_select_i ? 16'h0010 : 16'h0008))
			exp = '{fc | 8'h80, 8'h02};
		else begin
			exp = '{fc, 8'(2 * q)};
			for (int r = 0; r < q; r++) begin
				v = reg_val(fc, int'(a) + r);
				exp.push_back(v[15:8]);
				exp.push_back(v[7:0]);
			end
		end
		if (port != 16'h01f6) exp = {};
		repeat (80) begin
			tx_ready_i = !tx_ready_i;
			if (tx_valid_o === 1'b1 && tx_ready_i) begin
				got.push_back(tx_data_o);
				if (tx_last_o) begin
					fin = 1'b1;
					break;
				end
			end
			@(negedge ref_clk_i);
		end
		@(negedge ref_clk_i);
		tx_ready_i = 1'b0;
		cmp_count += 1 + exp.size();
		if (got.size() != exp.size()) miss("reply length");
		foreach (exp[i]) if (i < got.size() && got[i] !== exp[i]) miss("reply byte");
		if (exp.size() > 0 && !fin) miss("no last flag");
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_port();
		slv(8'h03, 16'h0000, 16'h0001, 16'h01f7);
		cmp_count++;
		if (tx_port_o !== 16'h01f6) miss("reply port");
	endtask
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			value_format_select_i = m[0];
			function_swap_select_i = m[1];
			slv(8'h03, 16'h0002, 16'h0004, 16'h01f6);
			slv(8'h04, 16'h0002, 16'h0004, 16'h01f6);
		end
	endtask
	task automatic t_limits();
		for (int m = 0; m < 2; m++) begin
			value_format_select_i = m[0];
			slv(8'h04, 16'h000e, 16'h0008, 16'h01f6);
			slv(8'h03, 16'h000f, 16'h0001, 16'h01f6);
			slv(8'h04, 16'h0000, m[0] ? 16'h0010 : 16'h0008, 16'h01f6);
			slv(8'h03, 16'h0000, m[0] ? 16'h0011 : 16'h0009, 16'h01f6);
			slv(8'h04, 16'h0001, 16'h0000, 16'h01f6);
		end
		slv(8'h05, 16'h0000, 16'h0001, 16'h01f6);
	endtask
	task automatic t_master(input logic e);
		logic [7:0] fr [5];
		fr = '{8'h04, 8'h00, 8'h02, 8'h00, 8'h02};
		exc = e;
		slow = 1'b1;
		modbus_send_command_i = 1'b1;
		mst_fc_i = 8'h04;
		mst_addr_i = 16'h0002;
		mst_qty_i = 16'h0002;
		@(negedge ref_clk_i);
		modbus_send_command_i = 1'b0;
		for (int t = 0; t < 200 && mst_done_o !== 1'b1; t++) @(negedge ref_clk_i);
		cmp_count += 8;
		if (mst_done_o !== 1'b1) miss("no completion");
		foreach (fr[i]) if (u_far.req[i] !== fr[i]) miss("request byte");
		if (response_function_query_o !== (e ? 8'h84 : 8'h04)) miss("reply code");
		if (exception_code_query_o !== (e ? 8'h02 : 8'h00)) miss("exception code");
		// Two registers asked for, so two array elements to read back
		for (int k = 0; k < 2 && !e; k++) begin
			analog_array_addr_i = k[3:0];
			@(negedge ref_clk_i);
			cmp_count++;
			if (analog_array_data_o !== {8'h30 + 8'(2 * k), 8'h31 + 8'(2 * k)}) miss("word");
		end
	endtask
	// ----
	// Sequence
	// ----
	initial forever #2 ref_clk_i = !ref_clk_i;
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miss("timeout");
			close_out();
		end
	end
	initial begin
		for (int i = 0; i < 8; i++) begin
			an_float_i[i*32+:32] = 32'h3f00a000 + i;
			ao_float_i[i*32+:32] = 32'h4100b000 + i;
			an_count_i[i*16+:16] = 16'h2500 + i[15:0];
			ao_count_i[i*16+:16] = 16'h6600 + i[15:0];
		end
		repeat (10) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		t_port();
		t_modes();
		t_limits();
		t_master(1'b0);
		t_master(1'b1);
		close_out();
	end
endmodule
